// ===== shared/pmt_consts.vh
`ifndef PMT_CONSTS_VH
`define PMT_CONSTS_VH

// Register word offsets (byte addresses on the bus are four times these).
`define PMT_IDX_COUNT 3'h0
`define PMT_IDX_CTRL 3'h1
`define PMT_IDX_PERIOD 3'h2
`define PMT_IDX_STATUS 3'h3
`define PMT_IDX_CLEAR 3'h4
`define PMT_IDX_ENABLE 3'h5
`define PMT_IDX_ROUTE 3'h6

// Control register fields.
`define PMT_CTRL_PRE_LO 1
`define PMT_CTRL_PRE_HI 0
`define PMT_CTRL_ON 2
`define PMT_CTRL_POST_HI 6
`define PMT_CTRL_POST_LO 3
`define PMT_CTRL_MASK 8'h7F

// Prescale select codes.
`define PMT_PRE_DIV1 2'h0
`define PMT_PRE_DIV4 2'h1

// Prescale terminal counts.
`define PMT_PRE_TC4 4'h3
`define PMT_PRE_TC16 4'hF

// Reset values.
`define PMT_COUNT_RST 8'h00
`define PMT_PERIOD_RST 8'hFF
`define PMT_CTRL_RST 8'h00

// Status and enable bit position of the match event flag.
`define PMT_FLAG_BIT 1

`endif

// ===== hdl/pmt_scaler.v
`timescale 1ns/1ps
`default_nettype none

// Clearable divider: pulses tick_out on every (term+1)-th tick_in.
module pmt_scaler #(
  parameter WIDTH = 4
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Control
  input wire clear,
  input wire [WIDTH-1:0] term,
  // Events
  input wire tick_in,
  output wire tick_out
);

  reg [WIDTH-1:0] cnt_reg;
  reg [WIDTH-1:0] cnt_next;

  assign tick_out = tick_in && (cnt_reg >= term);

  always @* begin
    cnt_next = cnt_reg;
    if (clear) begin
      cnt_next = {WIDTH{1'b0}};
    end else if (tick_in) begin
      if (cnt_reg >= term) begin
        cnt_next = {WIDTH{1'b0}};
      end else begin
        cnt_next = cnt_reg + {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      cnt_reg <= {WIDTH{1'b0}};
    end else begin
      cnt_reg <= cnt_next;
    end
  end

endmodule

`default_nettype wire

// ===== hdl/pmt_timer.v
// How it works
// R1: While on, the tick count rises by one from zero on each prescaled tick.
// R2: The input divider field picks divide by 1, 4 or 16 for codes 00, 01, 1x.
// R3: On each prescaled tick while on, the count is compared with the period limit; equality is a match pulse.
// R4: The cycle after a match forces the count to zero and the match clocks the postscaler.
// R5: Reset clears the count and loads the period limit with all ones.
// R6: Writing the count or control register, or reset, clears both scaler counters.
// R7: Writing the control register leaves the count unchanged.
// R8: Control bits 6 to 3 choose a postscale ratio of code plus one, 1:1 to 1:16.
// R9: Control bit 2 runs the timer when one and stops it when zero.
// R10: Control bit 7 reads zero and all control bits reset to zero.
// R11: The postscaler terminal count latches the match event flag, status bit 1.
// R12: The interrupt is raised only while the match event enable bit 1 is set.
// R13: The unscaled match pulse is given to the capture/compare/PWM units.
// R14: The match pulse is optionally given as the serial port shift clock.
// R15: Software may read and write the count and period limit at any time.
// R16: The flag is set after code plus one matches and stays set until cleared.
// R17: While off, count and scalers hold and no match or flag update occurs.
//
// Local design decisions: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "pmt_consts.vh"

module pmt_timer #(
  parameter PRE_WIDTH = 4,
  parameter POST_WIDTH = 4
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Avalon-MM slave
  input wire [4:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // Timer outputs
  output reg pwm_time_base,
  output reg spi_shift_clk,
  output reg irq
);

  reg [7:0] tick_count_reg;
  reg [7:0] period_limit_reg;
  reg [7:0] ctrl_reg;
  reg flag_reg;
  reg en_reg;
  reg spi_route_reg;
  reg answered_reg;
  reg [7:0] count_next;
  reg [3:0] pre_term;
  reg match;
  reg [31:0] rdata;

  wire access;
  wire take;
  wire wr;
  wire wr_count;
  wire wr_ctrl;
  wire wr_period;
  wire wr_clear;
  wire wr_enable;
  wire wr_route;
  wire scaler_clear;
  wire running;
  wire pre_tick;
  wire post_tick;
  wire [2:0] idx;

  // Every access takes exactly one wait cycle so read data can be registered.
  assign access = avs_read | avs_write;
  assign take = access & ~answered_reg;
  assign idx = avs_address[4:2];
  // A write lands only at the edge where waitrequest is seen low, as the
  // master holds its data until then.
  assign wr = access & answered_reg & avs_write & avs_byteenable[0];
  assign wr_count = wr && (idx == `PMT_IDX_COUNT);
  assign wr_ctrl = wr && (idx == `PMT_IDX_CTRL);
  assign wr_period = wr && (idx == `PMT_IDX_PERIOD);
  assign wr_clear = wr && (idx == `PMT_IDX_CLEAR);
  assign wr_enable = wr && (idx == `PMT_IDX_ENABLE);
  assign wr_route = wr && (idx == `PMT_IDX_ROUTE);

  assign scaler_clear = wr_count | wr_ctrl; // R6
  assign running = ctrl_reg[`PMT_CTRL_ON]; // R9

  // R2
  always @* begin
    if (ctrl_reg[`PMT_CTRL_PRE_HI+1:`PMT_CTRL_PRE_HI] == `PMT_PRE_DIV1) begin
      pre_term = 4'h0;
    end else if (ctrl_reg[`PMT_CTRL_PRE_HI+1:`PMT_CTRL_PRE_HI] ==
                 `PMT_PRE_DIV4) begin
      pre_term = `PMT_PRE_TC4;
    end else begin
      pre_term = `PMT_PRE_TC16;
    end
  end

  // Prescaler is clocked by every instruction cycle while on.
  pmt_scaler #(
    .WIDTH(PRE_WIDTH)
  ) u_pre (
    .clk(clk),
    .rst(rst),
    .clear(scaler_clear),
    .term(pre_term[PRE_WIDTH-1:0]),
    .tick_in(running), // R17
    .tick_out(pre_tick)
  );

  // R3
  always @* begin
    match = running && pre_tick && (tick_count_reg == period_limit_reg);
  end

  // Postscaler counts match pulses up to the selected ratio.
  pmt_scaler #(
    .WIDTH(POST_WIDTH)
  ) u_post (
    .clk(clk),
    .rst(rst),
    .clear(scaler_clear), // R6
    .term(ctrl_reg[`PMT_CTRL_POST_HI:`PMT_CTRL_POST_LO]), // R8
    .tick_in(match), // R4
    .tick_out(post_tick) // R16
  );

  always @* begin
    count_next = tick_count_reg;
    if (wr_count) begin
      count_next = avs_writedata[7:0]; // R15
    end else if (match) begin
      count_next = `PMT_COUNT_RST; // R4
    end else if (running && pre_tick) begin
      count_next = tick_count_reg + 8'h01; // R1
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      tick_count_reg <= `PMT_COUNT_RST; // R5
      period_limit_reg <= `PMT_PERIOD_RST; // R5
      ctrl_reg <= `PMT_CTRL_RST; // R10
    end else begin
      tick_count_reg <= count_next;
      if (wr_period) begin
        period_limit_reg <= avs_writedata[7:0]; // R15
      end
      if (wr_ctrl) begin
        ctrl_reg <= avs_writedata[7:0] & `PMT_CTRL_MASK; // R7 R10
      end
    end
  end

  // A postscaler terminal event in the same cycle as a clear wins.
  always @(posedge clk) begin
    if (rst) begin
      flag_reg <= 1'b0;
      en_reg <= 1'b0;
      spi_route_reg <= 1'b0;
    end else begin
      if (post_tick) begin
        flag_reg <= 1'b1; // R11
      end else if (wr_clear && avs_writedata[`PMT_FLAG_BIT]) begin
        flag_reg <= 1'b0; // R16
      end
      if (wr_enable) begin
        en_reg <= avs_writedata[`PMT_FLAG_BIT];
      end
      if (wr_route) begin
        spi_route_reg <= avs_writedata[0];
      end
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      pwm_time_base <= 1'b0;
      spi_shift_clk <= 1'b0;
      irq <= 1'b0;
    end else begin
      pwm_time_base <= match; // R13
      spi_shift_clk <= match & spi_route_reg; // R14
      irq <= (flag_reg | post_tick) & en_reg; // R12
    end
  end

  always @* begin
    rdata = 32'h0000_0000;
    if (idx == `PMT_IDX_COUNT) begin
      rdata[7:0] = tick_count_reg;
    end else if (idx == `PMT_IDX_CTRL) begin
      rdata[7:0] = ctrl_reg; // R10
    end else if (idx == `PMT_IDX_PERIOD) begin
      rdata[7:0] = period_limit_reg;
    end else if (idx == `PMT_IDX_STATUS) begin
      rdata[`PMT_FLAG_BIT] = flag_reg;
    end else if (idx == `PMT_IDX_ENABLE) begin
      rdata[`PMT_FLAG_BIT] = en_reg;
    end else if (idx == `PMT_IDX_ROUTE) begin
      rdata[0] = spi_route_reg;
    end
  end

  // Waitrequest is high only in the first cycle of an access.
  always @(posedge clk) begin
    if (rst) begin
      answered_reg <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      answered_reg <= take;
      if (take && avs_read) begin
        avs_readdata <= rdata;
      end
    end
  end

  always @* begin
    avs_waitrequest = access & ~answered_reg;
  end

endmodule

`default_nettype wire

// ===== dv/pmt_timer_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "pmt_consts.vh"
module pmt_timer_chk (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Register bus
  input wire [4:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  // Timer outputs
  input wire pwm_time_base,
  input wire spi_shift_clk,
  input wire irq
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  wire req = avs_read | avs_write;
  wire [2:0] idx = avs_address[4:2];
  wire wr_en = avs_write & !avs_waitrequest & avs_byteenable[0];
  wait_first_a: assert property ($rose(req) |-> avs_waitrequest)
    else $error("first access cycle not stalled");
  answer_next_a: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer one cycle later");
  upper_zero_a: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
  ctrl_top_a: assert property (avs_read && !avs_waitrequest && idx == `PMT_IDX_CTRL |-> !avs_readdata[7])
    else $error("control bit 7 reads one");
  reset_quiet_a: assert property (disable iff (1'b0) rst |=> !irq && !pwm_time_base && !spi_shift_clk)
    else $error("outputs active after reset");
  route_same_a: assert property (spi_shift_clk |-> pwm_time_base)
    else $error("shift clock without match");
  mask_off_a: assert property (wr_en && idx == `PMT_IDX_ENABLE && !avs_writedata[1] |=> ##1 !irq)
    else $error("interrupt while disabled");
  // A match launched just before the write may still pulse once.
  off_quiet_a: assert property (wr_en && idx == `PMT_IDX_CTRL && !avs_writedata[2] |=> ##1 !pwm_time_base [*3])
    else $error("match while timer off");
  cover property (pwm_time_base);
  cover property (irq);
  cover property (spi_shift_clk);
endmodule
bind pmt_timer pmt_timer_chk chk (.clk(clk), .rst(rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .pwm_time_base(pwm_time_base), .spi_shift_clk(spi_shift_clk), .irq(irq));
`default_nettype wire

// ===== dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "pmt_consts.vh"
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] adr = 5'h00;
  logic rd_q = 1'b0;
  logic wr_q = 1'b0;
  logic [31:0] wd = 32'h0000_0000;
  logic [31:0] v, v0;
  wire [31:0] rdat;
  wire wq, pwm, spi, irq;
  integer miscompares = 0;
  integer tests_run = 0;
  integer n, i, s;
  always #5 clk = ~clk;
  pmt_timer dut (.clk(clk), .rst(rst), .avs_address(adr), .avs_read(rd_q),
    .avs_write(wr_q), .avs_writedata(wd), .avs_byteenable(4'hF),
    .avs_readdata(rdat), .avs_waitrequest(wq), .pwm_time_base(pwm),
    .spi_shift_clk(spi), .irq(irq));
  task automatic acc(input logic w, input logic [2:0] x, input logic [7:0] d);
    begin
      @(posedge clk);
      adr <= {x, 2'b00};
      wd <= {24'h00_0000, d};
      wr_q <= w;
      rd_q <= !w;
      @(negedge clk);
      while (wq) begin
        @(posedge clk);
        @(negedge clk);
      end
      @(posedge clk);
      v = rdat;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
    end
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task automatic rc(input logic [2:0] x, input logic [31:0] exp);
    begin
      acc(1'b0, x, 8'h00);
      chk(v, exp);
    end
  endtask
  // Pulse to pulse, so the start-up phase of the count does not matter.
  task automatic gap(input integer exp);
    begin
      n = 1;
      @(negedge clk);
      while (!pwm) @(negedge clk);
      @(negedge clk);
      while (!pwm) begin
        n = n + 1;
        @(negedge clk);
      end
      chk(n, exp);
    end
  endtask
  task automatic print_verdict;
    begin
      $display("compares %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  initial begin
    #300000;
    miscompares = miscompares + 1;
    print_verdict;
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rc(`PMT_IDX_COUNT, 32'h0000_0000);
    rc(`PMT_IDX_PERIOD, 32'h0000_00FF);
    rc(`PMT_IDX_CTRL, 32'h0000_0000);
    rc(3'h7, 32'h0000_0000);
    acc(1'b1, `PMT_IDX_CTRL, 8'hFB);
    rc(`PMT_IDX_CTRL, 32'h0000_007B);
    acc(1'b1, `PMT_IDX_COUNT, 8'h5A);
    rc(`PMT_IDX_COUNT, 32'h0000_005A);
    acc(1'b1, `PMT_IDX_PERIOD, 8'h03);
    rc(`PMT_IDX_PERIOD, 32'h0000_0003);
    $display("register test done");
    for (i = 0; i < 4; i = i + 1) begin
      acc(1'b1, `PMT_IDX_CTRL, {5'h00, 1'b1, i[1:0]});
      gap(i == 0 ? 4 : i == 1 ? 16 : 64);
    end
    $display("prescale test done");
    acc(1'b1, `PMT_IDX_PERIOD, 8'h01);
    acc(1'b1, `PMT_IDX_ENABLE, 8'h02);
    for (i = 0; i < 16; i = i + 1) begin
      acc(1'b1, `PMT_IDX_CTRL, 8'h00);
      acc(1'b1, `PMT_IDX_CLEAR, 8'h02);
      rc(`PMT_IDX_STATUS, 32'h0000_0000);
      acc(1'b1, `PMT_IDX_COUNT, 8'h00);
      acc(1'b1, `PMT_IDX_CTRL, {1'b0, i[3:0], 3'h4});
      n = 0;
      s = 0;
      repeat (50) begin
        @(negedge clk);
        if (pwm && s == 0) n = n + 1;
        if (irq) s = 1;
      end
      chk(n, i + 1);
      rc(`PMT_IDX_STATUS, 32'h0000_0002);
    end
    chk(irq, 1'b1);
    acc(1'b1, `PMT_IDX_ENABLE, 8'h00);
    repeat (2) @(negedge clk);
    chk(irq, 1'b0);
    $display("postscale test done");
    acc(1'b1, `PMT_IDX_ROUTE, 8'h01);
    repeat (8) begin
      @(negedge clk);
      chk(spi, pwm);
    end
    acc(1'b1, `PMT_IDX_CTRL, 8'h00);
    acc(1'b0, `PMT_IDX_COUNT, 8'h00);
    v0 = v;
    repeat (20) @(posedge clk);
    rc(`PMT_IDX_COUNT, v0);
    acc(1'b1, `PMT_IDX_CTRL, 8'h78);
    rc(`PMT_IDX_COUNT, v0);
    $display("route and stop test done");
    print_verdict;
  end
endmodule
`default_nettype wire
